// ### dv/plr_link_model.sv
// Purpose: link controller model driving serial requests into the port
// Assumes: one request at a time, bits left aligned in an 18-bit word
// Notes: fair requests wait for an idle interface; immediate ones do not
module plr_link_model import plr_pkg::*; (
    // clock
    input wire logic clk_sys,
    // port pins
    input wire logic [1:0] control_pair,
    output logic link_request_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // line rests low between requests
    initial begin
        link_request_line = 1'b0;
    end

    // send n bits, bits[17] first; fair requests start a cycle after idle
    task automatic send(input logic [17:0] bits, input int n, input logic fair);
        int w;
        w = 0;
        if (fair) begin
            @(posedge clk_sys);
            while (control_pair !== PLR_CTL_IDLE && w < 100) begin
                @(posedge clk_sys);
                w++;
            end
            // an interface that never idles is a bench failure, not a silent start
            if (w >= 100) begin
                test_phy_link_request_status_port.failures++;
                test_phy_link_request_status_port.print_verdict();
            end
        end
        // one bit per clock, start bit first, stop bit always sent
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            link_request_line <= bits[17-i];
        end
        @(posedge clk_sys);
        link_request_line <= 1'b0;
    endtask
endmodule

// ### dv/test_phy_link_request_status_port.sv
// Purpose: self-checking bench for the link request/status port
// Assumes: apb slave answers in the first access cycle
// Notes: outputs sampled on the falling edge except in the apb task, which samples on the rising; inputs driven on the rising
module test_phy_link_request_status_port import plr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst, psel, penable, pwrite, rx_active, arb_won, gnt_null, pready, pslverr;
    logic link_request_line, phy_status_serial_line;
    logic [7:0] paddr, interface_data_lines;
    logic [31:0] pwdata, prdata;
    logic [1:0] control_pair;
    logic [3:0] arb_won_type;
    logic [6:0] stat_evt;
    logic [15:0] arb_pending;
    logic [2:0] note_pulse;
    plr_busreq_t gnt_info;
    int failures = 0;
    int total_checks = 0;

    // design and link model
    plr_port #(.ADDR_W(8)) dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_request_line(link_request_line), .control_pair(control_pair),
        .interface_data_lines(interface_data_lines), .phy_status_serial_line(phy_status_serial_line),
        .rx_active(rx_active), .arb_won(arb_won), .arb_won_type(arb_won_type), .stat_evt(stat_evt),
        .arb_pending(arb_pending), .gnt_info(gnt_info), .gnt_null(gnt_null), .note_pulse(note_pulse));
    plr_link_model link_u (.clk_sys(clk_sys), .control_pair(control_pair),
        .link_request_line(link_request_line));

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            failures++;
        end
    endtask

    // apb master: hold request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic wait_ctl(input logic [1:0] c, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (control_pair !== c && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        d = interface_data_lines;
        if (n >= 60) begin
            failures++;
            print_verdict();
        end
    endtask

    // capture one 17-bit register frame from the serial status line
    task automatic get_frame(output logic [16:0] f);
        int n;
        n = 0;
        f = '0;
        @(negedge clk_sys);
        while (phy_status_serial_line !== 1'b1 && n < 80) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 80) begin
            failures++;
            print_verdict();
        end
        for (int i = 0; i < 17; i++) begin
            f = {f[15:0], phy_status_serial_line};
            @(negedge clk_sys);
        end
    endtask

    task automatic pulse(input logic ev, input logic [3:0] t, input int b);
        @(posedge clk_sys);
        if (ev) stat_evt <= 7'(1 << b);
        else begin
            arb_won <= 1'b1;
            arb_won_type <= t;
        end
        @(posedge clk_sys);
        stat_evt <= '0;
        arb_won <= 1'b0;
    endtask

    function automatic logic [17:0] bus_req(input logic [3:0] t, input logic f, input logic [3:0] s);
        return {1'b1, t, f, s, 1'b0, 7'h00};
    endfunction

    // reset values, apb write/read back, unmapped access
    task automatic t_regs();
        logic [31:0] rd;
        logic e;
        apb(1'b0, PLR_A_CTRL, '0, rd, e);
        chk(rd, 32'(PLR_CTRL_RST));
        apb(1'b0, PLR_A_STATUS, '0, rd, e);
        chk(rd, 32'h0000_0000);
        apb(1'b1, PLR_A_PHYREG, 32'h0000_003C, rd, e);
        apb(1'b0, PLR_A_PHYREG, '0, rd, e);
        chk(rd, 32'h0000_003C);
        apb(1'b1, 8'h08, 32'h0000_0055, rd, e);
        apb(1'b0, 8'h08, '0, rd, e);
        chk({rd[30:0], e}, 32'h0000_0001);
        $display("t_regs done");
    endtask

    // each notification code gives its own pulse
    task automatic t_note();
        logic [2:0] acc;
        for (int i = 0; i < 3; i++) begin
            acc = '0;
            link_u.send({1'b1, PLR_T_NOTE_EVEN + 4'(i), 1'b0, 12'h000}, 6, 1'b0);
            repeat (4) begin
                @(negedge clk_sys);
                acc = acc | note_pulse;
            end
            chk(acc, 32'(1 << i));
        end
        $display("t_note done");
    endtask

    // overwrite of same type, then grant reports format and speed class
    task automatic t_busreq();
        logic [3:0] spd [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'hF};
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            link_u.send(bus_req(4'h2, 1'b0, 4'h0), 11, 1'b1);
            link_u.send(bus_req(4'h2, i[0], spd[i]), 11, 1'b1);
            @(negedge clk_sys);
            chk(arb_pending[2], 32'h1);
            pulse(1'b0, 4'h2, 0);
            wait_ctl(PLR_CTL_GRANT, d);
            chk({gnt_null, gnt_info}, {spd[i] > PLR_SPD_S800, i[0], spd[i]});
            @(negedge clk_sys);
            chk({control_pair, arb_pending[2]}, 32'h0);
        end
        $display("t_busreq done");
    endtask

    // link write with iso pending, reception keeps queue, immediate grant
    task automatic t_regwr();
        logic [31:0] rd;
        logic [7:0] d;
        logic e;
        link_u.send(bus_req(4'h6, 1'b0, 4'h4), 11, 1'b1);
        link_u.send({1'b1, PLR_T_REG_WR, 4'h5, 8'hA5, 1'b0}, 18, 1'b0);
        apb(1'b0, PLR_A_PHYREG + 8'h14, '0, rd, e);
        chk(rd, 32'h0000_00A5);
        rx_active <= 1'b1;
        link_u.send(bus_req(PLR_T_IMMED, 1'b0, 4'h0), 11, 1'b0);
        wait_ctl(PLR_CTL_RECV, d);
        chk({arb_pending[6], arb_pending[1]}, 32'h3);
        @(posedge clk_sys);
        rx_active <= 1'b0;
        wait_ctl(PLR_CTL_GRANT, d);
        @(negedge clk_sys);
        chk({control_pair, arb_pending[6], arb_pending[1]}, 32'h2);
        pulse(1'b0, 4'h6, 0);
        wait_ctl(PLR_CTL_GRANT, d);
        @(negedge clk_sys);
        chk(arb_pending[6], 32'h0);
        $display("t_regwr done");
    endtask

    // read returns a frame; a second read while outstanding is dropped
    task automatic t_regrd();
        logic [16:0] f;
        logic v;
        v = 1'b0;
        fork
            begin
                link_u.send({1'b1, PLR_T_REG_RD, 4'h5, 1'b0, 8'h00}, 10, 1'b0);
                link_u.send({1'b1, PLR_T_REG_RD, 4'h6, 1'b0, 8'h00}, 10, 1'b0);
            end
            get_frame(f);
        join
        chk(f, {1'b1, PLR_PS_SOL, 4'h5, 8'hA5, 1'b0});
        repeat (40) begin
            @(negedge clk_sys);
            v = v | phy_status_serial_line;
        end
        chk(v, 32'h0);
        $display("t_regrd done");
    endtask

    // one-hot bus status, inactive interface, bus reset
    task automatic t_status();
        logic [31:0] rd;
        logic [16:0] f;
        logic [7:0] d;
        logic e, v;
        for (int b = 1; b < 7; b++) begin
            pulse(1'b1, 4'h0, b);
            wait_ctl(PLR_CTL_STATUS, d);
            chk(d, 32'(1 << b));
            @(negedge clk_sys);
            chk(control_pair, 32'(PLR_CTL_IDLE));
        end
        apb(1'b1, PLR_A_CTRL, '0, rd, e);
        pulse(1'b1, 4'h0, 3);
        v = 1'b0;
        repeat (10) begin
            @(negedge clk_sys);
            v = v | (control_pair === PLR_CTL_STATUS);
        end
        chk(v, 32'h0);
        apb(1'b1, PLR_A_CTRL, 32'h0000_0001, rd, e);
        wait_ctl(PLR_CTL_STATUS, d);
        chk(d, 32'h0000_0008);
        link_u.send(bus_req(4'h3, 1'b0, 4'h2), 11, 1'b1);
        pulse(1'b1, 4'h0, 0);
        fork
            wait_ctl(PLR_CTL_STATUS, d);
            get_frame(f);
        join
        chk(d, 32'h0000_0001);
        chk(f, {1'b1, PLR_PS_UNSOL, 4'h0, 8'h3C, 1'b0});
        chk(arb_pending, 32'h0);
        $display("t_status done");
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        rx_active = 1'b0;
        arb_won = 1'b0;
        arb_won_type = '0;
        stat_evt = '0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_note();
        t_busreq();
        t_regwr();
        t_regrd();
        t_status();
        print_verdict();
    end
endmodule

// ### pkg/plr_pkg.sv
// Purpose: shared constants and types for the link request/status port
// Assumes: one interface clock, synchronous active-high reset
// Notes: APB map is word aligned, 32-bit data
package plr_pkg;
    // request type codes
    localparam logic [3:0] PLR_T_IMMED = 4'h1;
    localparam logic [3:0] PLR_T_CYC_START = 4'h8;
    localparam logic [3:0] PLR_T_REG_RD = 4'hA;
    localparam logic [3:0] PLR_T_REG_WR = 4'hB;
    localparam logic [3:0] PLR_T_NOTE_EVEN = 4'hC;
    localparam logic [3:0] PLR_T_NOTE_ODD = 4'hD;
    localparam logic [3:0] PLR_T_NOTE_DUE = 4'hE;
    // index of the last sampled bit per request kind
    localparam logic [4:0] PLR_TYPE_LAST = 5'd4;
    localparam logic [4:0] PLR_LAST_BUS = 5'd9;
    localparam logic [4:0] PLR_LAST_RD = 5'd9;
    localparam logic [4:0] PLR_LAST_WR = 5'd17;
    localparam logic [4:0] PLR_LAST_NOTE = 5'd5;
    // speed codes and rate classes
    localparam logic [3:0] PLR_SPD_S100 = 4'h0;
    localparam logic [3:0] PLR_SPD_S200 = 4'h2;
    localparam logic [3:0] PLR_SPD_S400 = 4'h4;
    localparam logic [3:0] PLR_SPD_S800 = 4'h6;
    localparam logic [3:0] PLR_SPD_MAXRES = 4'h7;
    // control pair codes
    localparam logic [1:0] PLR_CTL_IDLE = 2'b00;
    localparam logic [1:0] PLR_CTL_STATUS = 2'b01;
    localparam logic [1:0] PLR_CTL_RECV = 2'b10;
    localparam logic [1:0] PLR_CTL_GRANT = 2'b11;
    localparam logic [7:0] PLR_DATA_ON = 8'hFF;
    // bus status bit positions
    localparam int PLR_BS_N = 7;
    localparam int PLR_BS_BUS_RESET = 0;
    localparam int PLR_BS_IF_RESET = 6;
    // serial status frame
    localparam logic [2:0] PLR_PS_SOL = 3'b010;
    localparam logic [2:0] PLR_PS_UNSOL = 3'b011;
    localparam logic [4:0] PLR_PS_LAST = 5'd16;
    // register map and reset values
    localparam logic [7:0] PLR_A_CTRL = 8'h00;
    localparam logic [7:0] PLR_A_STATUS = 8'h04;
    localparam logic [7:0] PLR_A_PHYREG = 8'h40;
    localparam logic PLR_CTRL_RST = 1'b1;
    localparam logic [7:0] PLR_PREG_RST = 8'h00;
    // queued bus request contents
    typedef struct packed {
        logic fmt;
        logic [3:0] spd;
    } plr_busreq_t;
    // one cycle on the control pair and data lines
    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] data;
    } plr_link_out_t;
    typedef enum logic [1:0] {PLR_ST_IDLE = 2'b00, PLR_ST_SHIFT = 2'b01} plr_state_t;
endpackage

// ### verilog/plr_port.sv
// Purpose: request decoder, bus request queue and status sender of the link port
// Assumes: link request line synchronous to clk_sys; cable side gives events
// Notes: packet data transfer and cable arbitration live elsewhere
//
// The address map and the APB register port were chosen for this implementation.
module plr_port import plr_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link controller pins
    input wire logic link_request_line,
    output logic [1:0] control_pair,
    output logic [7:0] interface_data_lines,
    output logic phy_status_serial_line,
    // cable side
    input wire logic rx_active,
    input wire logic arb_won,
    input wire logic [3:0] arb_won_type,
    input wire logic [PLR_BS_N-1:0] stat_evt,
    output logic [15:0] arb_pending,
    output plr_busreq_t gnt_info,
    output logic gnt_null,
    output logic [2:0] note_pulse
);
    if (ADDR_W < 8) begin : g_chk
        $error("plr_port: ADDR_W must be at least 8");
    end

    plr_state_t st_r;
    logic [4:0] cnt_r, ps_cnt_r;
    logic [17:0] sh_r, sh_nxt;
    logic [3:0] typ_r, gnt_type, rd_addr_r, ps_addr;
    logic done, is_bus, rx_prev_r, rx_fall, gnt_fire, bus_rst;
    logic [15:0] pend_r;
    plr_busreq_t q_r [16];
    logic ctrl_r, ifr_r, send_st;
    logic [PLR_BS_N-1:0] stat_pend_r, pick;
    plr_link_out_t lo_r;
    logic rd_pend_r, uns_pend_r;
    logic [16:0] ps_sh_r;
    logic ps_line_r, ps_sol_r, ps_load, ps_done;
    logic [7:0] preg_r [16];
    logic iso_odd_r, apb_wr, hit_ctrl, hit_stat, hit_win;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // last bit index of a request, by its type
    function automatic logic [4:0] last_bit(input logic [3:0] t);
        if (t == PLR_T_REG_RD) begin
            return PLR_LAST_RD;
        end else if (t == PLR_T_REG_WR) begin
            return PLR_LAST_WR;
        end else if (t[3:2] == 2'b11 || t == 4'h0 || t == 4'h5 || t == 4'h9) begin
            return PLR_LAST_NOTE;
        end
        return PLR_LAST_BUS;
    endfunction

    // incoming bit joins at the bottom, so earlier bits sit higher
    assign sh_nxt = {sh_r[16:0], link_request_line};
    assign done = (st_r == PLR_ST_SHIFT) && (cnt_r > PLR_TYPE_LAST) && (cnt_r == last_bit(typ_r));
    assign is_bus = (typ_r inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, PLR_T_CYC_START});

    // deserialiser; bus requests end at bit 9 so a dropped stop bit is harmless
    always_ff @(posedge clk_sys) begin
        if (rst || ifr_r) begin
            st_r <= PLR_ST_IDLE;
            cnt_r <= 5'd0;
            sh_r <= '0;
            typ_r <= 4'h0;
        end else begin
            case (st_r)
                PLR_ST_IDLE: begin
                    sh_r <= sh_nxt;
                    cnt_r <= 5'd1;
                    if (link_request_line) begin
                        st_r <= PLR_ST_SHIFT;
                    end
                end
                PLR_ST_SHIFT: begin
                    sh_r <= sh_nxt;
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == PLR_TYPE_LAST) begin
                        typ_r <= sh_nxt[3:0];
                    end
                    if (done) begin
                        st_r <= PLR_ST_IDLE;
                    end
                end
                default: st_r <= PLR_ST_IDLE;
            endcase
        end
    end

    // grant on a won arbitration or when reception ends with immediate queued
    assign rx_fall = rx_prev_r && !rx_active;
    assign gnt_fire = !ifr_r && ((rx_fall && pend_r[PLR_T_IMMED]) || (arb_won && pend_r[arb_won_type]));
    assign gnt_type = (rx_fall && pend_r[PLR_T_IMMED]) ? PLR_T_IMMED : arb_won_type;
    assign bus_rst = stat_evt[PLR_BS_BUS_RESET];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_prev_r <= 1'b0;
        end else begin
            rx_prev_r <= rx_active;
        end
    end

    // request queue; reception start touches nothing here
    always_ff @(posedge clk_sys) begin
        if (rst || bus_rst) begin
            pend_r <= 16'h0000;
        end else begin
            if (gnt_fire) begin
                pend_r[gnt_type] <= 1'b0;
            end
            if (done && is_bus) begin
                pend_r[typ_r] <= 1'b1;
            end
        end
    end

    // stored format and speed, overwritten by a newer request of the type
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 16; i++) begin
            if (rst) begin
                q_r[i] <= '0;
            end else if (done && is_bus && typ_r == 4'(i)) begin
                q_r[i] <= '{fmt: sh_nxt[4], spd: sh_nxt[3:0]};
            end
        end
    end

    // grant details for the transmit path
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gnt_info <= '0;
            gnt_null <= 1'b0;
        end else begin
            gnt_null <= 1'b0;
            if (gnt_fire) begin
                gnt_info <= q_r[gnt_type];
                gnt_null <= q_r[gnt_type].spd[3] || q_r[gnt_type].spd == PLR_SPD_MAXRES;
            end
        end
    end

    // link notifications and isochronous phase
    always_ff @(posedge clk_sys) begin
        if (rst || bus_rst) begin
            iso_odd_r <= 1'b0;
            note_pulse <= 3'b000;
        end else begin
            note_pulse <= 3'b000;
            if (done && typ_r[3:2] == 2'b11) begin
                if (typ_r == PLR_T_NOTE_EVEN) begin
                    iso_odd_r <= 1'b0;
                    note_pulse[0] <= 1'b1;
                end else if (typ_r == PLR_T_NOTE_ODD) begin
                    iso_odd_r <= 1'b1;
                    note_pulse[1] <= 1'b1;
                end else if (typ_r == PLR_T_NOTE_DUE) begin
                    note_pulse[2] <= 1'b1;
                end
            end
        end
    end

    // status events wait while the interface is inactive or resetting, lowest bit first
    assign pick = stat_pend_r & (~stat_pend_r + 7'h01);
    assign send_st = ctrl_r && !ifr_r && !gnt_fire && (stat_pend_r != '0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_pend_r <= '0;
            ifr_r <= 1'b0;
        end else begin
            // a new event in the clearing cycle is kept
            stat_pend_r <= (stat_pend_r & ~(send_st ? pick : '0)) | stat_evt;
            ifr_r <= send_st && pick[PLR_BS_IF_RESET];
        end
    end

    // control pair and data lines; grant outranks status, status outranks receive
    always_ff @(posedge clk_sys) begin
        if (rst || ifr_r) begin
            lo_r <= '{ctl: PLR_CTL_IDLE, data: 8'h00};
        end else if (gnt_fire) begin
            lo_r <= '{ctl: PLR_CTL_GRANT, data: 8'h00};
        end else if (send_st) begin
            lo_r <= '{ctl: PLR_CTL_STATUS, data: {1'b0, pick}};
        end else if (rx_active) begin
            lo_r <= '{ctl: PLR_CTL_RECV, data: PLR_DATA_ON};
        end else begin
            lo_r <= '{ctl: PLR_CTL_IDLE, data: 8'h00};
        end
    end
    assign control_pair = lo_r.ctl;
    assign interface_data_lines = lo_r.data;

    // outstanding register read; later reads dropped, bus reset spares it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 4'h0;
        end else if (done && typ_r == PLR_T_REG_RD && !rd_pend_r) begin
            rd_pend_r <= 1'b1;
            rd_addr_r <= sh_nxt[4:1];
        end else if (ps_done && ps_sol_r) begin
            rd_pend_r <= 1'b0;
        end
    end

    // unsolicited register 0 after a bus reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            uns_pend_r <= 1'b0;
        end else if (bus_rst) begin
            uns_pend_r <= 1'b1;
        end else if (ps_load && uns_pend_r) begin
            uns_pend_r <= 1'b0;
        end
    end

    // serial status sender; unsolicited goes first since it follows a reset
    assign ps_load = (ps_cnt_r == 5'd0) && ctrl_r && (uns_pend_r || rd_pend_r) && !ps_line_r;
    assign ps_done = (ps_cnt_r == 5'd1);
    assign ps_addr = uns_pend_r ? 4'h0 : rd_addr_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ps_sh_r <= '0;
            ps_cnt_r <= 5'd0;
            ps_line_r <= 1'b0;
            ps_sol_r <= 1'b0;
        end else if (ps_load) begin
            ps_line_r <= 1'b1;
            ps_sh_r <= {uns_pend_r ? PLR_PS_UNSOL : PLR_PS_SOL, ps_addr, preg_r[ps_addr], 2'b00};
            ps_cnt_r <= PLR_PS_LAST;
            ps_sol_r <= !uns_pend_r;
        end else if (ps_cnt_r != 5'd0) begin
            ps_line_r <= ps_sh_r[16];
            ps_sh_r <= {ps_sh_r[15:0], 1'b0};
            ps_cnt_r <= ps_cnt_r - 5'd1;
        end else begin
            ps_line_r <= 1'b0;
        end
    end
    assign phy_status_serial_line = ps_line_r;

    // apb decode
    assign hit_ctrl = ({paddr[ADDR_W-1:2], 2'b00} == ADDR_W'(PLR_A_CTRL));
    assign hit_stat = ({paddr[ADDR_W-1:2], 2'b00} == ADDR_W'(PLR_A_STATUS));
    assign hit_win = ((paddr >> 6) == (ADDR_W'(PLR_A_PHYREG) >> 6));
    assign apb_wr = psel && penable && pready && pwrite;

    // register file; the link write wins over a same-cycle software write
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 16; i++) begin
            if (rst) begin
                preg_r[i] <= PLR_PREG_RST;
            end else if (done && typ_r == PLR_T_REG_WR && sh_nxt[12:9] == 4'(i)) begin
                preg_r[i] <= sh_nxt[8:1];
            end else if (apb_wr && hit_win && paddr[5:2] == 4'(i)) begin
                preg_r[i] <= pwdata[7:0];
            end
        end
    end

    // control register: interface active enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r <= PLR_CTRL_RST;
        end else if (apb_wr && hit_ctrl) begin
            ctrl_r <= pwdata[0];
        end
    end

    // no wait states: data is fetched in setup, ready in first access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable && !pready;
            if (psel && !penable) begin
                pslverr <= 1'b0;
                if (hit_ctrl) begin
                    prdata <= {31'h0000_0000, ctrl_r};
                end else if (hit_stat) begin
                    prdata <= {13'h0000, iso_odd_r, uns_pend_r, rd_pend_r, pend_r};
                end else if (hit_win) begin
                    prdata <= {24'h00_0000, preg_r[paddr[5:2]]};
                end else begin
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            end
        end
    end
    assign arb_pending = pend_r;

    AST_GRANT_CODE: assert property (gnt_fire |=> control_pair == PLR_CTL_GRANT)
        else $error("grant not shown on control pair");
    AST_STATUS_ONEHOT: assert property (control_pair == PLR_CTL_STATUS |->
        $onehot(interface_data_lines) && !interface_data_lines[7])
        else $error("status transfer not one-hot");
    AST_STATUS_ACTIVE: assert property (control_pair == PLR_CTL_STATUS |-> $past(ctrl_r))
        else $error("status sent while interface inactive");
    AST_WR_LOAD: assert property (done && typ_r == PLR_T_REG_WR |=>
        preg_r[$past(sh_nxt[12:9])] == $past(sh_nxt[8:1]))
        else $error("register write not loaded");
    AST_RD_HOLD: assert property (rd_pend_r && !ps_done |=> rd_pend_r && $stable(rd_addr_r))
        else $error("outstanding read disturbed");
    AST_BUSRST_DROP: assert property (bus_rst |=> pend_r == 16'h0000 && uns_pend_r && !iso_odd_r)
        else $error("bus reset did not clear queue");
    AST_IF_RESET: assert property (control_pair == PLR_CTL_STATUS && interface_data_lines[6] |->
        ifr_r ##1 (st_r == PLR_ST_IDLE && control_pair == PLR_CTL_IDLE))
        else $error("interface reset late");
    AST_QUEUE_SET: assert property (done && is_bus && !bus_rst |=>
        pend_r[$past(typ_r)] && q_r[$past(typ_r)].spd == $past(sh_nxt[3:0]))
        else $error("bus request not queued");
    AST_NULL_PKT: assert property (gnt_fire && q_r[gnt_type].spd[3] |=> gnt_null)
        else $error("invalid speed grant lacks null flag");
    AST_READ_FRAME: assert property (ps_load && !uns_pend_r |=>
        phy_status_serial_line ##1 !phy_status_serial_line ##1 phy_status_serial_line)
        else $error("solicited frame header wrong");
endmodule
